// ===== hw/pressure_sensor_pkg.sv
// Shared constants and types for the pressure sensor command port
package pressure_sensor_pkg;

   // Bus addressing and command encodings
   localparam logic [6:0]  SLAVE_ADDR       = 7'h76;
   localparam logic [7:0]  CMD_RESET        = 8'h1E;
   localparam logic [7:0]  CMD_ADC_READ     = 8'h00;
   localparam logic [3:0]  CMD_CONV_P_HI    = 4'h4;
   localparam logic [3:0]  CMD_CONV_T_HI    = 4'h5;
   localparam logic [3:0]  CMD_PROM_HI      = 4'hA;
   localparam logic [2:0]  OSR_MAX_IDX      = 3'h5;
   localparam logic [2:0]  PROM_LAST_ADDR   = 3'h6;

   // Field positions inside a command byte
   localparam int          CMD_HI_MSB       = 7;
   localparam int          CMD_HI_LSB       = 4;
   localparam int          CMD_SEL_MSB      = 3;
   localparam int          CMD_SEL_LSB      = 1;
   localparam int          CMD_KIND_BIT     = 4;

   // Sizes
   localparam int          PROM_WORDS       = 7;
   localparam int          RESULT_BITS      = 24;
   localparam int          PROM_BITS        = 16;
   localparam int          OSR_COUNT        = 6;
   localparam logic [3:0]  BIT_CNT_BYTE     = 4'h8;
   localparam logic [7:0]  PROM_PAD         = 8'h00;

   // Pattern folded into a result that was disturbed while converting
   localparam logic [23:0] CORRUPT_MASK     = 24'hA5A5A5;

   // Longest conversion times per oversampling ratio 256..8192, in units of 10 us
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned CONV_TIME_10US [OSR_COUNT] = '{60, 117, 228, 454, 904, 1810};
   localparam int unsigned CONV_SCALE       = 10;
   localparam int          CONV_CNT_W       = 21;

   typedef logic [15:0] prom_word_t;

   // Arbitrary neutral factory contents
   localparam prom_word_t FACTORY_PROM_DEFAULT [PROM_WORDS] =
      '{16'h0000, 16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666};

   typedef enum logic [7:0] {
      ST_IDLE     = 8'h01,
      ST_ADDR     = 8'h02,
      ST_ADDR_ACK = 8'h04,
      ST_CMD      = 8'h08,
      ST_CMD_ACK  = 8'h10,
      ST_TX       = 8'h20,
      ST_TX_ACK   = 8'h40,
      ST_IGNORE   = 8'h80
   } link_state_t;

endpackage

// ===== hw/pressure_sensor_cmd_port.sv
// I2C command port of the pressure sensor: link slave, calibration store, conversion timing
// Functional notes
// R1 - Answer only to address 1110110; last address bit 0 writes, 1 reads.
// R2 - Master frames each transaction with start and stop conditions.
// R3 - Commands are one byte after write address; address and command both acknowledged.
// R4 - Reset command 0x1E reloads calibration contents into internal register.
// R5 - Reset command is honoured at any moment from any internal state.
// R6 - Master frees a stuck SDA by clocking SCL then sending reset.
// R7 - 0x40..0x4A start pressure, 0x50..0x5A temperature; step selects ratio.
// R8 - After command 0x00 a read transaction returns the 24-bit result.
// R9 - Calibration reads 0xA0..0xAE; bits three to one give word address.
// R10 - Calibration store holds seven 16-bit words, 112 bits.
// R11 - Calibration read: write carries command, separate read fetches data.
// R12 - Selected calibration word is shifted out MSB first.
// R13 - Result read without conversion, or repeated, returns zero.
// R14 - Result read during conversion returns zero and corrupts that conversion.
// R15 - Master sends no conversion command while one is running.
// R16 - Busy from accepted conversion until done; only then result readable.
// R17 - Result is 24 bits MSB first, acknowledge awaited after each byte.
// R18 - Word zero holds factory configuration and checksum.
// R19 - Master acknowledges first calibration byte, refuses second, then stops.
// R20 - Master waits the longest conversion time before reading the result.
`timescale 1ns/1ps
module pressure_sensor_cmd_port
   import pressure_sensor_pkg::*;
#(
   parameter int unsigned CONV_CYCLES [OSR_COUNT] = '{
      CONV_TIME_10US[0] * CLK_MHZ * CONV_SCALE, CONV_TIME_10US[1] * CLK_MHZ * CONV_SCALE,
      CONV_TIME_10US[2] * CLK_MHZ * CONV_SCALE, CONV_TIME_10US[3] * CLK_MHZ * CONV_SCALE,
      CONV_TIME_10US[4] * CLK_MHZ * CONV_SCALE, CONV_TIME_10US[5] * CLK_MHZ * CONV_SCALE},
   parameter prom_word_t FACTORY_PROM [PROM_WORDS] = FACTORY_PROM_DEFAULT
)(
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   scl,
   input  wire logic                   sda_in,
   output      logic                   sda_out,
   output      logic                   sda_oe,
   input  wire logic [RESULT_BITS-1:0] raw_pressure_sample,
   input  wire logic [RESULT_BITS-1:0] raw_temperature_sample,
   output      logic                   conv_busy
);

   logic [2:0]             scl_sync_reg;
   logic [2:0]             sda_sync_reg;
   logic                   scl_f_reg;
   logic                   sda_f_reg;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_cond;
   logic                   stop_cond;
   link_state_t            state_reg;
   logic [3:0]             bit_cnt_reg;
   logic [7:0]             shift_reg;
   logic                   rw_reg;
   logic                   ack_ok_reg;
   logic [RESULT_BITS-1:0] tx_buf_reg;
   logic                   sda_oe_reg;
   logic [7:0]             cmd_reg;
   logic                   cmd_exec_reg;
   prom_word_t             prom_reg [PROM_WORDS];
   logic [RESULT_BITS-1:0] read_buf_reg;
   logic [RESULT_BITS-1:0] result_reg;
   logic                   result_valid_reg;
   logic                   conv_busy_reg;
   logic                   conv_kind_reg;
   logic                   corrupt_reg;
   logic [CONV_CNT_W-1:0]  conv_cnt_reg;
   logic                   conv_done;
   logic                   is_reset_cmd;
   logic                   is_read_cmd;

   function automatic logic is_conv(input logic [7:0] c);
      logic [3:0] hi;
      hi = c[CMD_HI_MSB:CMD_HI_LSB];
      return (hi == CMD_CONV_P_HI || hi == CMD_CONV_T_HI) && !c[0]
             && c[CMD_SEL_MSB:CMD_SEL_LSB] <= OSR_MAX_IDX;
   endfunction

   function automatic logic is_prom(input logic [7:0] c);
      return c[CMD_HI_MSB:CMD_HI_LSB] == CMD_PROM_HI && !c[0];
   endfunction

   function automatic logic [CONV_CNT_W-1:0] conv_load(input logic [2:0] idx);
      return CONV_CNT_W'(CONV_CYCLES[idx] - 1);
   endfunction

   // Word seven is not populated and reads as zero
   function automatic prom_word_t prom_at(input logic [2:0] a);
      return (a <= PROM_LAST_ADDR) ? prom_reg[a] : '0;
   endfunction

   // Three-stage sampling of the link pins, a change counts once stages two and three agree
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         scl_f_reg    <= 1'b1;
         sda_f_reg    <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
         if (scl_sync_reg[1] == scl_sync_reg[2])
            scl_f_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2])
            sda_f_reg <= sda_sync_reg[2];
      end
   end

   assign scl_rise   = (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2] && !scl_f_reg;
   assign scl_fall   = (scl_sync_reg[1] == scl_sync_reg[2]) && !scl_sync_reg[2] && scl_f_reg;
   assign start_cond = (sda_sync_reg[1] == sda_sync_reg[2]) && !sda_sync_reg[2] && sda_f_reg
                       && scl_f_reg;
   assign stop_cond  = (sda_sync_reg[1] == sda_sync_reg[2]) && sda_sync_reg[2] && !sda_f_reg
                       && scl_f_reg;

   // Link state machine; start and stop always resynchronise, which also frees a stuck bus
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg    <= ST_IDLE;
         bit_cnt_reg  <= 4'h0;
         shift_reg    <= 8'h00;
         rw_reg       <= 1'b0;
         ack_ok_reg   <= 1'b0;
         tx_buf_reg   <= '0;
         sda_oe_reg   <= 1'b0;
         cmd_reg      <= 8'h00;
         cmd_exec_reg <= 1'b0;
      end
      else
      begin
         cmd_exec_reg <= 1'b0;
         if (start_cond)
         begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
         end
         else if (stop_cond)
         begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
         end
         else
         begin
            case (state_reg)
               ST_ADDR, ST_CMD:
               begin
                  if (scl_rise)
                  begin
                     shift_reg   <= {shift_reg[6:0], sda_f_reg};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_reg == BIT_CNT_BYTE)
                  begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == ST_CMD)
                     begin
                        state_reg    <= ST_CMD_ACK;
                        sda_oe_reg   <= 1'b1; // R3
                        cmd_reg      <= shift_reg;
                        cmd_exec_reg <= 1'b1; // R3
                     end
                     else if (shift_reg[7:1] == SLAVE_ADDR) // R1
                     begin
                        state_reg  <= ST_ADDR_ACK;
                        sda_oe_reg <= 1'b1;
                        rw_reg     <= shift_reg[0]; // R1
                     end
                     else
                        state_reg <= ST_IGNORE;
                  end
               end
               ST_ADDR_ACK:
                  if (scl_fall)
                  begin
                     bit_cnt_reg <= 4'h0;
                     if (rw_reg)
                     begin
                        state_reg  <= ST_TX; // R11
                        tx_buf_reg <= read_buf_reg;
                        sda_oe_reg <= !read_buf_reg[RESULT_BITS-1];
                     end
                     else
                     begin
                        state_reg  <= ST_CMD;
                        sda_oe_reg <= 1'b0;
                     end
                  end
               ST_CMD_ACK:
                  if (scl_fall)
                  begin
                     state_reg  <= ST_IGNORE; // R3
                     sda_oe_reg <= 1'b0;
                  end
               ST_TX:
                  if (scl_rise)
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  else if (scl_fall)
                  begin
                     tx_buf_reg <= {tx_buf_reg[RESULT_BITS-2:0], 1'b0}; // R12 R17
                     if (bit_cnt_reg == BIT_CNT_BYTE)
                     begin
                        state_reg   <= ST_TX_ACK; // R17
                        bit_cnt_reg <= 4'h0;
                        sda_oe_reg  <= 1'b0;
                     end
                     else
                        sda_oe_reg <= !tx_buf_reg[RESULT_BITS-2];
                  end
               ST_TX_ACK:
                  if (scl_rise)
                     ack_ok_reg <= !sda_f_reg;
                  else if (scl_fall)
                  begin
                     if (ack_ok_reg)
                     begin
                        state_reg  <= ST_TX; // R17
                        sda_oe_reg <= !tx_buf_reg[RESULT_BITS-1];
                     end
                     else
                        state_reg <= ST_IGNORE;
                  end
               default:
                  sda_oe_reg <= 1'b0;
            endcase
         end
      end
   end

   assign sda_out      = 1'b0;
   assign sda_oe       = sda_oe_reg;
   assign conv_busy    = conv_busy_reg;
   assign is_reset_cmd = cmd_exec_reg && cmd_reg == CMD_RESET;
   assign is_read_cmd  = cmd_exec_reg && cmd_reg == CMD_ADC_READ;
   assign conv_done    = conv_busy_reg && conv_cnt_reg == '0;

   // Calibration store, zero until the first reset command
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         prom_reg <= '{default: '0};
      else if (is_reset_cmd) // R4 R5
         for (int i = 0; i < PROM_WORDS; i++)
            prom_reg[i] <= FACTORY_PROM[i]; // R10 R18
   end

   // Conversion timing, result capture and disturbance tracking
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         conv_busy_reg    <= 1'b0;
         conv_kind_reg    <= 1'b0;
         corrupt_reg      <= 1'b0;
         conv_cnt_reg     <= '0;
         result_reg       <= '0;
         result_valid_reg <= 1'b0;
      end
      else if (is_reset_cmd)
      begin
         conv_busy_reg    <= 1'b0; // R5
         corrupt_reg      <= 1'b0;
         result_valid_reg <= 1'b0;
      end
      else
      begin
         if (is_read_cmd)
            result_valid_reg <= 1'b0; // R13
         if (conv_done)
         begin
            conv_busy_reg    <= 1'b0; // R16
            result_reg       <= (conv_kind_reg ? raw_temperature_sample : raw_pressure_sample)
                                ^ (corrupt_reg ? CORRUPT_MASK : '0); // R14
            result_valid_reg <= 1'b1; // R16
            corrupt_reg      <= 1'b0;
         end
         else if (conv_busy_reg)
            conv_cnt_reg <= conv_cnt_reg - 1'b1;
         if (cmd_exec_reg && (is_conv(cmd_reg) || is_read_cmd) && conv_busy_reg && !conv_done)
            corrupt_reg <= 1'b1; // R14 R15
         else if (cmd_exec_reg && is_conv(cmd_reg))
         begin
            conv_busy_reg <= 1'b1; // R16
            conv_kind_reg <= cmd_reg[CMD_KIND_BIT]; // R7
            conv_cnt_reg  <= conv_load(cmd_reg[CMD_SEL_MSB:CMD_SEL_LSB]); // R7
         end
      end
   end

   // Data staged for the next read transaction
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         read_buf_reg <= '0;
      else if (is_read_cmd)
         read_buf_reg <= (result_valid_reg && !conv_busy_reg) ? result_reg : '0; // R8 R13 R14
      else if (cmd_exec_reg && is_prom(cmd_reg))
         read_buf_reg <= {prom_at(cmd_reg[CMD_SEL_MSB:CMD_SEL_LSB]), PROM_PAD}; // R9 R12
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_addr_match_ack: assert property (state_reg == ST_ADDR && scl_fall // R1
      && !start_cond && !stop_cond
      && bit_cnt_reg == BIT_CNT_BYTE && shift_reg[7:1] == SLAVE_ADDR
      |=> state_reg == ST_ADDR_ACK && sda_oe_reg ##1 sda_oe_reg)
      else $error("matching address not acknowledged");
   a_addr_other_quiet: assert property (state_reg == ST_ADDR && scl_fall // R1
      && !start_cond && !stop_cond
      && bit_cnt_reg == BIT_CNT_BYTE && shift_reg[7:1] != SLAVE_ADDR
      |=> !sda_oe_reg && state_reg == ST_IGNORE)
      else $error("foreign address acknowledged");
   a_cmd_byte_ack: assert property (state_reg == ST_CMD && scl_fall // R3
      && !start_cond && !stop_cond && bit_cnt_reg == BIT_CNT_BYTE
      |=> sda_oe_reg && cmd_exec_reg && cmd_reg == $past(shift_reg))
      else $error("command byte not acknowledged or not executed");
   a_reset_reload: assert property (is_reset_cmd // R4
      |=> prom_reg[1] == FACTORY_PROM[1] && prom_reg[6] == FACTORY_PROM[6] && !conv_busy_reg)
      else $error("reset command did not reload calibration");
   a_conv_load_osr: assert property (cmd_exec_reg && is_conv(cmd_reg) && !conv_busy_reg // R7
      |=> conv_busy_reg && conv_cnt_reg == conv_load($past(cmd_reg[CMD_SEL_MSB:CMD_SEL_LSB])))
      else $error("conversion not started with the selected ratio");
   a_busy_min_hold: assert property ($rose(conv_busy_reg) |-> conv_busy_reg [*8]) // R16
      else $error("conversion ended too early");
   a_done_valid: assert property (conv_done && !cmd_exec_reg // R16
      |=> result_valid_reg && !conv_busy_reg)
      else $error("finished conversion not readable");
   a_read_busy_zero: assert property (is_read_cmd && conv_busy_reg && !conv_done // R14
      |=> read_buf_reg == '0 ##1 corrupt_reg || !conv_busy_reg)
      else $error("read during conversion not zero");
   a_read_again_zero: assert property (is_read_cmd && !result_valid_reg // R13
      |=> read_buf_reg == '0)
      else $error("repeated result read not zero");
   a_prom_word_msb: assert property (cmd_exec_reg && is_prom(cmd_reg) && !is_reset_cmd // R12
      |=> read_buf_reg[RESULT_BITS-1 -: PROM_BITS]
          == prom_at($past(cmd_reg[CMD_SEL_MSB:CMD_SEL_LSB])))
      else $error("calibration word not staged MSB first");
   a_tx_ack_release: assert property (state_reg == ST_TX_ACK |-> !sda_oe_reg) // R17
      else $error("data line held during master acknowledge");

endmodule

// ===== dv/i2c_master_model.sv
// Two-wire bus master model that drives the sensor link
`timescale 1ns/1ps
module i2c_master_model (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   localparam realtime Q = 31.25;

   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // One bit: data set mid-low, sampled mid-high; a released line shows the pull-up
   task automatic bit_xfer(input logic b, output logic s);
      #Q sda_low = ~b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
   endtask

   task automatic start_cond();
      #Q sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask

   task automatic stop_cond();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], s);
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask

   task automatic recv_byte(input logic give_ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_xfer(1'b1, d[i]);
      bit_xfer(~give_ack, s);
   endtask

   task automatic frame_write(input logic [7:0] a, input logic [7:0] c, output logic [1:0] acks);
      start_cond();
      send_byte(a, acks[1]);
      send_byte(c, acks[0]);
      stop_cond();
   endtask

   task automatic frame_read(input logic [7:0] a, input int n, output logic [23:0] d,
                             output logic ack);
      logic [7:0] b;
      d = '0;
      start_cond();
      send_byte(a, ack);
      for (int k = 0; k < n; k++)
      begin
         recv_byte(k < n - 1, b);
         d = {d[15:0], b};
      end
      stop_cond();
   endtask

   // Clocks out a stuck transfer with the line released, then closes the frame
   task automatic recover(input int pulses);
      logic s;
      for (int k = 0; k < pulses; k++)
         bit_xfer(1'b1, s);
      stop_cond();
   endtask
endmodule

// ===== dv/pressure_sensor_cmd_port_tb.sv
// Self-checking bench for the sensor command port
`timescale 1ns/1ps
module pressure_sensor_cmd_port_tb
   import pressure_sensor_pkg::*;
;
   localparam int unsigned CONV_TB [OSR_COUNT] = '{300, 320, 340, 360, 380, 400};
   localparam prom_word_t  PROM_TB [PROM_WORDS] =
      '{16'hC3A5, 16'h8E17, 16'h4D2B, 16'hB961, 16'h2F7C, 16'hE058, 16'h7A94};
   localparam logic [7:0]  WR_ADDR = {SLAVE_ADDR, 1'b0};
   localparam logic [7:0]  RD_ADDR = {SLAVE_ADDR, 1'b1};

   logic        clk;
   logic        reset_n;
   logic        scl;
   logic        sda_low;
   logic        sda_wire;
   logic        sda_out;
   logic        sda_oe;
   logic [23:0] raw_pressure_sample;
   logic [23:0] raw_temperature_sample;
   logic        conv_busy;
   int          fails = 0;
   int          cmp_count = 0;
   int          busy_len = 0;
   int          last_len = 0;

   assign sda_wire = ~sda_low & (sda_oe ? sda_out : 1'b1);

   pressure_sensor_cmd_port #(
      .CONV_CYCLES  (CONV_TB),
      .FACTORY_PROM (PROM_TB)
   ) i_dut (
      .clk                    (clk),
      .reset_n                (reset_n),
      .scl                    (scl),
      .sda_in                 (sda_wire),
      .sda_out                (sda_out),
      .sda_oe                 (sda_oe),
      .raw_pressure_sample    (raw_pressure_sample),
      .raw_temperature_sample (raw_temperature_sample),
      .conv_busy              (conv_busy)
   );

   i2c_master_model i_master (
      .scl     (scl),
      .sda_low (sda_low),
      .sda     (sda_wire)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Length of the last busy span in clock cycles
   always @(posedge clk)
   begin
      if (conv_busy === 1'b1)
         busy_len <= busy_len + 1;
      else if (busy_len != 0)
      begin
         last_len <= busy_len;
         busy_len <= 0;
      end
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] c);
      logic [1:0] a;
      i_master.frame_write(WR_ADDR, c, a);
      check(a, 2'b11);
   endtask

   task automatic rd(input int n, output logic [23:0] d);
      logic a;
      i_master.frame_read(RD_ADDR, n, d, a);
      check(a, 1'b1);
   endtask

   task automatic adc(output logic [23:0] d);
      cmd(CMD_ADC_READ);
      rd(3, d);
   endtask

   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (conv_busy !== lvl && n < 2000)
      begin
         @(posedge clk);
         #1 n++;
      end
      repeat (2) @(posedge clk);
      #1 check(conv_busy, lvl);
   endtask

   task automatic t_blank();
      logic [23:0] d;
      cmd({CMD_PROM_HI, 3'h3, 1'b0});
      rd(2, d);
      check(d, 24'h0);
      adc(d);
      check(d, 24'h0);
   endtask

   task automatic t_prom();
      logic [23:0] d;
      cmd(CMD_RESET);
      for (int a = 0; a < 8; a++)
      begin
         cmd({CMD_PROM_HI, a[2:0], 1'b0});
         rd(2, d);
         check(d, a < PROM_WORDS ? {8'h0, PROM_TB[a]} : 24'h0);
      end
   endtask

   task automatic t_refused();
      logic [1:0]  a;
      logic [23:0] d;
      logic        k;
      i_master.frame_write(WR_ADDR ^ 8'h02, CMD_RESET, a);
      check(a, 2'b00);
      i_master.frame_read(RD_ADDR ^ 8'h80, 1, d, k);
      check(k, 1'b0);
      cmd(8'h4C);
      check(conv_busy, 1'b0);
   endtask

   task automatic t_conv();
      logic [23:0] d;
      logic [23:0] exp;
      for (int k = 0; k < 12; k++)
      begin
         @(posedge clk);
         #1 raw_pressure_sample = 24'hC35A10 + k;
         raw_temperature_sample = 24'h3CA5E0 + k;
         exp = k < 6 ? raw_pressure_sample : raw_temperature_sample;
         cmd({k < 6 ? CMD_CONV_P_HI : CMD_CONV_T_HI, 3'(k % 6), 1'b0});
         wait_busy(1'b0);
         check(last_len, CONV_TB[k % 6]);
         adc(d);
         check(d, exp);
         adc(d);
         check(d, 24'h0);
      end
   endtask

   task automatic t_overlap();
      logic [23:0] d;
      cmd({CMD_CONV_T_HI, OSR_MAX_IDX, 1'b0});
      cmd(CMD_ADC_READ);
      check(conv_busy, 1'b1);
      rd(3, d);
      check(d, 24'h0);
      wait_busy(1'b0);
      adc(d);
      check(d, raw_temperature_sample ^ CORRUPT_MASK);
   endtask

   task automatic t_reset_mid();
      logic [23:0] d;
      cmd({CMD_CONV_P_HI, 3'h4, 1'b0});
      cmd(CMD_RESET);
      check(conv_busy, 1'b0);
      adc(d);
      check(d, 24'h0);
   endtask

   task automatic t_recover();
      logic        k;
      logic [23:0] d;
      i_master.start_cond();
      i_master.send_byte(RD_ADDR, k);
      i_master.recover(9);
      cmd(CMD_RESET);
      cmd({CMD_PROM_HI, 3'h1, 1'b0});
      rd(2, d);
      check(d, {8'h0, PROM_TB[1]});
   endtask

   initial
   begin
      reset_n = 1'b0;
      raw_pressure_sample = 24'h0;
      raw_temperature_sample = 24'h0;
      repeat (20) @(posedge clk);
      #1 check(conv_busy, 1'b0);
      reset_n = 1'b1;
      repeat (4) @(posedge clk);
      t_blank();
      t_prom();
      t_refused();
      t_conv();
      t_overlap();
      t_reset_mid();
      t_recover();
      summarize();
   end

   // Whole run needs about 400 us of link traffic
   initial
   begin
      #800000;
      fails++;
      summarize();
   end
endmodule
